// >>> verilog/bcfs_defs.svh
// constants of the buck channel fault supervisor
// Function
// - PWM drives high, low or tri-state
// - hold 1.6 V level 20 ns entering tri-state
// - start/stop by command or pin, start also by input voltage, with delays
// - turn-on accepted only after turn-off completes
// - pre-bias: switch once soft-start reference reaches feedback
// - power good window in run and turn-off delay, else low
// - truncate cycle on peak overcurrent
// - three overcurrent counts stop switches, hiccup default
// - soft-start overcurrent only limits cycles
// - overcurrent response: latch or retry after seven rises
// - slave channel follows channel one response
// - undervoltage acts like overcurrent response
// - overvoltage: low side on, hard start
// - voltage faults only on master channel
// - external overtemperature off, restart below hysteresis
// - junction hot stops PWM, cool restarts soft-start
// - pull shared fault line on own faults except overvoltage
// - external fault line low shuts channel
// - restart only after every phase releases line
// - overvoltage PWM low, other faults tri-state
`ifndef BCFS_DEFS_SVH
`define BCFS_DEFS_SVH
`define BCFS_ADDR_CTRL      8'h00
`define BCFS_ADDR_TON       8'h04
`define BCFS_ADDR_TOFF      8'h08
`define BCFS_ADDR_SS        8'h0C
`define BCFS_ADDR_STATUS    8'h10
`define BCFS_ADDR_FLAGS     8'h14
`define BCFS_CTRL_RST       5'h12
`define BCFS_DLY_RST        16'h0000
`define BCFS_SS_RST         16'h0100
`define BCFS_CLK_PERIOD_NS  8
`define BCFS_TRI_HOLD_NS    20
`define BCFS_TRI_HOLD_CYC   ((`BCFS_TRI_HOLD_NS + `BCFS_CLK_PERIOD_NS - 1) / `BCFS_CLK_PERIOD_NS)
`define BCFS_OC_TRIP        2'h3
`define BCFS_HICCUP_MULT    3'h7
`endif

// >>> verilog/bcfs_pkg.sv
// types of the buck channel fault supervisor
package bcfs_pkg;
  typedef enum logic [2:0] {
    ST_OFF  = 3'h0, ST_TONW = 3'h1, ST_SS  = 3'h3, ST_RUN = 3'h2,
    ST_TOFFW = 3'h6, ST_OVH = 3'h7, ST_FLT = 3'h5, ST_REL = 3'h4
  } bcfs_state_t;
  typedef enum logic [2:0] {
    CA_NONE = 3'h0, CA_OC = 3'h1, CA_VINUV = 3'h2, CA_UV = 3'h3,
    CA_OV = 3'h4, CA_OT = 3'h5, CA_JT = 3'h6, CA_EXT = 3'h7
  } bcfs_cause_t;
  typedef enum logic [1:0] {PW_TRI = 2'h0, PW_LO = 2'h1, PW_HI = 2'h3} bcfs_pwm_t;
  typedef struct packed {
    logic master;
    logic slave;
    logic usePin;
    logic retry;
    logic opOn;
  } bcfs_cfg_t;
  typedef struct packed {
    logic swCycleStart;
    logic pwmDemand;
    logic ocPeak;
    logic ssRefAtFb;
    logic fbBelowGood;
    logic fbAboveGood;
    logic fbUnder;
    logic fbOver;
    logic vinAboveOn;
    logic vinBelowOff;
    logic extOtHot;
    logic extOtCool;
    logic junctHot;
    logic junctCool;
    logic controlPin;
    logic faultLineIn;
    logic leaderRetry;
  } bcfs_sense_t;
endpackage : bcfs_pkg

// >>> verilog/bcfs_top.sv
// channel sequencing, PWM level control and fault supervision with APB registers
`timescale 1ns/10ps
`include "bcfs_defs.svh"
module bcfs_top import bcfs_pkg::*; #(
  parameter int TIMER_W = 20
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // analog comparators and pins, asynchronous
  input  wire bcfs_sense_t senseIn,
  // pwm pin to the power stage
  output logic             pwmOut,
  output logic             pwmOe,
  output logic             pwmMidDrive,
  // open-drain power good and shared fault line
  output logic             goodOut,
  output logic             goodOe,
  output logic             faultOut,
  output logic             faultOe
);

  // ****************************************
  // parameter check
  // ****************************************
  if (TIMER_W < 19) begin : g_chk
    $error("TIMER_W must hold seven soft-start times");
  end

  // ****************************************
  // reset release and input synchronisers
  // ****************************************
  logic        rstMeta_reg;
  logic        rstSync_reg;
  bcfs_sense_t senseMeta_reg;
  bcfs_sense_t sense_reg;
  logic        cycleDly_reg;
  logic        pinDly_reg;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      senseMeta_reg <= '0;
      sense_reg     <= '0;
      cycleDly_reg  <= 1'b0;
      pinDly_reg    <= 1'b0;
    end else begin
      senseMeta_reg <= senseIn;
      sense_reg     <= senseMeta_reg;
      cycleDly_reg  <= sense_reg.swCycleStart;
      pinDly_reg    <= sense_reg.controlPin;
    end
  end

  logic cycleStart;
  logic pinFell;
  assign cycleStart = sense_reg.swCycleStart & ~cycleDly_reg;
  assign pinFell    = pinDly_reg & ~sense_reg.controlPin;

  // ****************************************
  // registers
  // ****************************************
  bcfs_cfg_t          cfg_reg;
  logic [15:0]        tonDly_reg;
  logic [15:0]        toffDly_reg;
  logic [15:0]        ssTime_reg;
  logic [6:0]         flags_reg;
  bcfs_state_t        state_reg;
  bcfs_cause_t        cause_reg;
  logic [TIMER_W-1:0] timer_reg;
  logic [1:0]         ocCnt_reg;
  logic               ocSeen_reg;
  logic               vinOk_reg;
  logic               ssBegun_reg;
  bcfs_pwm_t          pwmLvl_reg;
  logic [1:0]         midCnt_reg;

  function automatic logic isSwitching(input bcfs_state_t st);
    isSwitching = (st == ST_SS) || (st == ST_RUN) || (st == ST_TOFFW);
  endfunction : isSwitching

  function automatic logic isPostSs(input bcfs_state_t st);
    isPostSs = (st == ST_RUN) || (st == ST_TOFFW);
  endfunction : isPostSs

  logic apbSetup;
  logic apbWrite;
  logic mapped;
  assign apbSetup = psel & ~penable;
  assign apbWrite = psel & penable & pready & pwrite;
  assign mapped   = (paddr == `BCFS_ADDR_CTRL) || (paddr == `BCFS_ADDR_TON) || (paddr == `BCFS_ADDR_TOFF) ||
                    (paddr == `BCFS_ADDR_SS) || (paddr == `BCFS_ADDR_STATUS) || (paddr == `BCFS_ADDR_FLAGS);

  always_ff @(posedge clk_sys or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      cfg_reg     <= `BCFS_CTRL_RST;
      tonDly_reg  <= `BCFS_DLY_RST;
      toffDly_reg <= `BCFS_DLY_RST;
      ssTime_reg  <= `BCFS_SS_RST;
    end else if (apbWrite) begin
      case (paddr)
        `BCFS_ADDR_CTRL: cfg_reg     <= pwdata[4:0];
        `BCFS_ADDR_TON:  tonDly_reg  <= pwdata[15:0];
        `BCFS_ADDR_TOFF: toffDly_reg <= pwdata[15:0];
        `BCFS_ADDR_SS:   ssTime_reg  <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (apbSetup) begin
        pslverr <= ~mapped;
        case (paddr)
          `BCFS_ADDR_CTRL:   prdata <= {27'h0, cfg_reg};
          `BCFS_ADDR_TON:    prdata <= {16'h0, tonDly_reg};
          `BCFS_ADDR_TOFF:   prdata <= {16'h0, toffDly_reg};
          `BCFS_ADDR_SS:     prdata <= {16'h0, ssTime_reg};
          `BCFS_ADDR_STATUS: prdata <= {22'h0, vinOk_reg, ocCnt_reg, goodOe, cause_reg, state_reg};
          `BCFS_ADDR_FLAGS:  prdata <= {25'h0, flags_reg};
          default:           prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************
  // fault detection
  // ****************************************
  logic        retryEff;
  logic        enableReq;
  bcfs_cause_t detCause;
  logic        inWindow;
  logic        ownDrive;
  assign retryEff  = cfg_reg.slave ? sense_reg.leaderRetry : cfg_reg.retry;
  assign enableReq = cfg_reg.opOn & (sense_reg.controlPin | ~cfg_reg.usePin) & vinOk_reg;
  assign inWindow  = ~sense_reg.fbBelowGood & ~sense_reg.fbAboveGood;
  assign ownDrive  = (state_reg == ST_FLT) && (cause_reg != CA_EXT) && (cause_reg != CA_OV);

  always_comb begin
    detCause = CA_NONE;
    if (sense_reg.junctHot) begin
      detCause = CA_JT;
    end else if (sense_reg.extOtHot) begin
      detCause = CA_OT;
    end else if (!vinOk_reg) begin
      detCause = CA_VINUV;
    end else if (!sense_reg.faultLineIn) begin
      detCause = CA_EXT;
    end else if (isPostSs(state_reg) && cfg_reg.master && sense_reg.fbOver) begin
      detCause = CA_OV;
    end else if (isPostSs(state_reg) && cfg_reg.master && sense_reg.fbUnder) begin
      detCause = CA_UV;
    end else if (isPostSs(state_reg) && ocCnt_reg == `BCFS_OC_TRIP) begin
      detCause = CA_OC;
    end
  end

  // hiccup wait is seven soft-start times, soft-start standing in for the rise time
  logic [TIMER_W-1:0] hiccupLoad;
  assign hiccupLoad = TIMER_W'(ssTime_reg) * TIMER_W'(`BCFS_HICCUP_MULT);

  always_ff @(posedge clk_sys or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      vinOk_reg <= 1'b0;
    end else if (sense_reg.vinBelowOff) begin
      vinOk_reg <= 1'b0;
    end else if (sense_reg.vinAboveOn) begin
      vinOk_reg <= 1'b1;
    end
  end

  // ****************************************
  // channel sequencer
  // ****************************************
  logic timerZero;
  assign timerZero = (timer_reg == '0);

  always_ff @(posedge clk_sys or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      state_reg <= ST_OFF;
      cause_reg <= CA_NONE;
      timer_reg <= '0;
    end else begin
      if (!timerZero) begin
        timer_reg <= timer_reg - 1'b1;
      end
      if (state_reg != ST_OFF && state_reg != ST_FLT && state_reg != ST_REL && state_reg != ST_OVH &&
          detCause != CA_NONE) begin
        cause_reg <= detCause;
        timer_reg <= hiccupLoad;
        state_reg <= (detCause == CA_OV) ? ST_OVH : ST_FLT;
      end else begin
        case (state_reg)
          ST_OFF: begin
            if (enableReq) begin
              state_reg <= ST_TONW;
              timer_reg <= TIMER_W'(tonDly_reg);
            end
          end
          ST_TONW: begin
            if (!enableReq) begin
              state_reg <= ST_OFF;
            end else if (timerZero) begin
              state_reg <= ST_SS;
              timer_reg <= TIMER_W'(ssTime_reg);
            end
          end
          ST_SS: begin
            if (!enableReq) begin
              state_reg <= ST_TOFFW;
              timer_reg <= TIMER_W'(toffDly_reg);
            end else if (timerZero && ssBegun_reg) begin
              state_reg <= ST_RUN;
            end
          end
          ST_RUN: begin
            if (!enableReq) begin
              state_reg <= ST_TOFFW;
              timer_reg <= TIMER_W'(toffDly_reg);
            end
          end
          // turn-on requests are ignored until the delay has run out
          ST_TOFFW: begin
            if (timerZero) begin
              state_reg <= ST_OFF;
            end
          end
          ST_OVH: begin
            if (inWindow) begin
              state_reg <= ST_RUN;
              cause_reg <= CA_NONE;
            end
          end
          ST_FLT: begin
            case (cause_reg)
              CA_OC, CA_UV: begin
                if (retryEff ? timerZero : pinFell) begin
                  state_reg <= ST_REL;
                end
              end
              CA_VINUV: if (vinOk_reg) state_reg <= ST_REL;
              CA_OT:    if (sense_reg.extOtCool) state_reg <= ST_REL;
              CA_JT:    if (sense_reg.junctCool) state_reg <= ST_REL;
              default:  state_reg <= ST_REL;
            endcase
          end
          ST_REL: begin
            if (sense_reg.faultLineIn) begin
              state_reg <= ST_OFF;
              cause_reg <= CA_NONE;
            end
          end
          default: state_reg <= ST_OFF;
        endcase
      end
    end
  end

  // ****************************************
  // sticky fault flags, write one to clear, set wins
  // ****************************************
  for (genvar i = 0; i < 7; i++) begin : g_flag
    always_ff @(posedge clk_sys or negedge rstSync_reg) begin
      if (!rstSync_reg) begin
        flags_reg[i] <= 1'b0;
      end else if (state_reg != ST_FLT && state_reg != ST_OVH && detCause == bcfs_cause_t'(i + 1) &&
                   state_reg != ST_OFF && state_reg != ST_REL) begin
        flags_reg[i] <= 1'b1;
      end else if (apbWrite && paddr == `BCFS_ADDR_FLAGS && pwdata[i]) begin
        flags_reg[i] <= 1'b0;
      end
    end
  end

  // ****************************************
  // overcurrent counting
  // ****************************************
  always_ff @(posedge clk_sys or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      ocSeen_reg <= 1'b0;
      ocCnt_reg  <= 2'h0;
    end else begin
      if (cycleStart) begin
        ocSeen_reg <= sense_reg.ocPeak;
      end else if (sense_reg.ocPeak) begin
        ocSeen_reg <= 1'b1;
      end
      // soft-start never accumulates, so overcurrent there only limits the cycle
      if (!isPostSs(state_reg)) begin
        ocCnt_reg <= 2'h0;
      end else if (cycleStart) begin
        if (!ocSeen_reg) begin
          ocCnt_reg <= 2'h0;
        end else if (ocCnt_reg != `BCFS_OC_TRIP) begin
          ocCnt_reg <= ocCnt_reg + 2'h1;
        end
      end
    end
  end

  // ****************************************
  // pwm level and tri-state hold
  // ****************************************
  bcfs_pwm_t pwmTarget;
  always_comb begin
    pwmTarget = PW_TRI;
    if (state_reg == ST_OVH) begin
      pwmTarget = PW_LO;
    end else if (isSwitching(state_reg) && (ssBegun_reg || state_reg != ST_SS)) begin
      pwmTarget = (sense_reg.pwmDemand && !ocSeen_reg && !sense_reg.ocPeak) ? PW_HI : PW_LO;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      ssBegun_reg <= 1'b0;
    end else if (!isSwitching(state_reg) && state_reg != ST_OVH) begin
      ssBegun_reg <= 1'b0;
    end else if (state_reg == ST_SS && sense_reg.ssRefAtFb) begin
      ssBegun_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      pwmLvl_reg  <= PW_TRI;
      pwmOut      <= 1'b0;
      pwmOe       <= 1'b0;
      pwmMidDrive <= 1'b0;
      midCnt_reg  <= 2'h0;
    end else begin
      pwmLvl_reg <= pwmTarget;
      pwmOut     <= (pwmTarget == PW_HI);
      pwmOe      <= (pwmTarget != PW_TRI);
      if (pwmTarget != PW_TRI) begin
        pwmMidDrive <= 1'b0;
        midCnt_reg  <= 2'h0;
      end else if (pwmLvl_reg != PW_TRI) begin
        pwmMidDrive <= 1'b1;
        midCnt_reg  <= 2'(`BCFS_TRI_HOLD_CYC);
      end else if (midCnt_reg > 2'h1) begin
        midCnt_reg <= midCnt_reg - 2'h1;
      end else begin
        pwmMidDrive <= 1'b0;
        midCnt_reg  <= 2'h0;
      end
    end
  end

  // ****************************************
  // power good and fault line
  // ****************************************
  always_ff @(posedge clk_sys or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      goodOut  <= 1'b0;
      goodOe   <= 1'b1;
      faultOut <= 1'b0;
      faultOe  <= 1'b0;
    end else begin
      goodOe  <= ~(isPostSs(state_reg) && inWindow);
      faultOe <= ownDrive;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstSync_reg);

  sequence s_ocTrip;
    state_reg == ST_RUN && detCause == CA_OC;
  endsequence
  sequence s_triFollows;
    state_reg == ST_FLT ##1 !pwmOe;
  endsequence

  AST_TRI_START: assert property ($fell(pwmOe) |-> pwmMidDrive) else $error("no mid drive on tri");
  AST_TRI_END: assert property (pwmMidDrive [*3] |=> !pwmMidDrive) else $error("mid drive too long");
  AST_PG_SS: assert property (state_reg == ST_SS |=> goodOe) else $error("power good in soft-start");
  AST_OC_SS: assert property (state_reg == ST_SS |=> !(state_reg == ST_FLT && cause_reg == CA_OC))
    else $error("oc fault from soft-start");
  AST_OC_TRIP: assert property (s_ocTrip |=> s_triFollows) else $error("oc trip missed");
  AST_OV_LOW: assert property (state_reg == ST_OVH |=> pwmOe && !pwmOut) else $error("ov pwm not low");
  AST_FLT_PULL: assert property (ownDrive |=> faultOe) else $error("fault line not pulled");
  AST_EXT_OFF: assert property (state_reg == ST_RUN && detCause == CA_EXT |=> state_reg == ST_FLT ##1 !pwmOe)
    else $error("external fault ignored");
  AST_TRUNC: assert property (isSwitching(state_reg) && sense_reg.ocPeak |=> !pwmOut)
    else $error("cycle not truncated");
  AST_REL_WAIT: assert property (state_reg == ST_REL && !sense_reg.faultLineIn |=> state_reg == ST_REL)
    else $error("restart before line release");
  AST_OV_MASTER: assert property ($rose(state_reg == ST_OVH) |-> $past(cfg_reg.master))
    else $error("voltage fault on slave");
  AST_TOFF: assert property (state_reg == ST_TOFFW |=> state_reg != ST_TONW && state_reg != ST_SS)
    else $error("turn-on during turn-off delay");

endmodule : bcfs_top

// >>> sim/bcfs_stage_model.sv
// behavioural power stage that decodes the three-level pwm pin
`timescale 1ns/10ps
module bcfs_stage_model (
  // clock
  input  wire logic clk_sys,
  // pwm pin as the controller drives it
  input  wire logic pwmOut,
  input  wire logic pwmOe,
  input  wire logic pwmMidDrive,
  // switch states and length of the last mid-level burst
  output logic      hsOn,
  output logic      lsOn,
  output int        midLen
);
  int midRun;

  // a released or mid-driven pin sits at the divider level, so both switches stay off
  assign hsOn = pwmOe & pwmOut & ~pwmMidDrive;
  assign lsOn = pwmOe & ~pwmOut & ~pwmMidDrive;

  initial begin
    midRun = 0;
    midLen = 0;
  end

  // length of each mid-level burst, measured in clock cycles
  always @(posedge clk_sys) begin
    if (pwmMidDrive) begin
      midRun <= midRun + 1;
    end else if (midRun != 0) begin
      midLen <= midRun;
      midRun <= 0;
    end
  end
endmodule : bcfs_stage_model

// >>> sim/testbench.sv
// self-checking bench of the buck channel fault supervisor
`timescale 1ns/10ps
module testbench import bcfs_pkg::*;;
  logic        clk_sys;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  bcfs_sense_t sense;
  bcfs_sense_t senseW;
  logic        extPull;
  logic        pwmOut;
  logic        pwmOe;
  logic        pwmMidDrive;
  logic        goodOut;
  logic        goodOe;
  logic        faultOut;
  logic        faultOe;
  logic        hsOn;
  logic        lsOn;
  int          midLen;
  int          n_fail;
  int          total_checks;
  int          seed;
  int          expFlags;
  logic [31:0] rd;
  logic        err;
  logic        d;

  always #4 clk_sys = ~clk_sys;

  // shared fault line is a wired-and of this channel and another phase
  always_comb begin
    senseW = sense;
    senseW.faultLineIn = ~(faultOe | extPull);
  end

  bcfs_top #(.TIMER_W(20)) i_bcfs_top (
    .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .senseIn(senseW), .pwmOut(pwmOut), .pwmOe(pwmOe), .pwmMidDrive(pwmMidDrive),
    .goodOut(goodOut), .goodOe(goodOe), .faultOut(faultOut), .faultOe(faultOe));

  bcfs_stage_model i_bcfs_stage_model (
    .clk_sys(clk_sys), .pwmOut(pwmOut), .pwmOe(pwmOe), .pwmMidDrive(pwmMidDrive),
    .hsOn(hsOn), .lsOn(lsOn), .midLen(midLen));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    // no wait-state count is assumed; only the watchdog ends a hung access
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // polls the state field; the bound stands in for a hung sequencer
  task automatic wait_state(input logic [2:0] exp);
    int n;
    n = 0;
    do begin
      apb(1'b0, 8'h10, 32'h0);
      n++;
    end while (rd[2:0] !== exp && n < 300);
    chk(32'(rd[2:0]), 32'(exp));
  endtask : wait_state

  // peak lies inside the ending cycle only, so the new cycle opens clean
  task automatic oc_cycle(input logic peak);
    sense.ocPeak <= peak;
    repeat (4) @(posedge clk_sys);
    sense.ocPeak <= 1'b0;
    repeat (4) @(posedge clk_sys);
    sense.swCycleStart <= 1'b1;
    repeat (4) @(posedge clk_sys);
    sense.swCycleStart <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : oc_cycle

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    extPull = 1'b0;
    sense = '0;
    sense.vinAboveOn = 1'b1; // input thresholds alike in every controller
    sense.extOtCool = 1'b1;
    sense.junctCool = 1'b1;
    seed = 70;
    n_fail = 0;
    total_checks = 0;
    expFlags = 0;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(32'(goodOe), 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h12);
    chk(32'(err), 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    // one controller only, so its delays match any partner by construction
    apb(1'b1, 8'h04, 32'h4);
    apb(1'b1, 8'h08, 32'h14);
    apb(1'b1, 8'h0C, 32'h4);
    apb(1'b1, 8'h00, 32'h13);
    wait_state(3'h3);
    chk({30'h0, pwmOe, goodOe}, 32'h1);
    repeat (3) oc_cycle(1'b1);
    wait_state(3'h3);
    sense.ssRefAtFb <= 1'b1;
    wait_state(3'h2);
    repeat (4) @(posedge clk_sys);
    chk(32'(goodOe), 32'h0);
    repeat (8) begin
      d = 1'($random(seed));
      sense.pwmDemand <= d;
      repeat (6) @(posedge clk_sys);
      chk({30'h0, hsOn, lsOn}, {30'h0, d, ~d});
    end
    sense.pwmDemand <= 1'b1;
    sense.ocPeak <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk(32'(hsOn), 32'h0);
    sense.ocPeak <= 1'b0;
    sense.fbAboveGood <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk(32'(goodOe), 32'h1);
    sense.fbAboveGood <= 1'b0;
    repeat (2) oc_cycle(1'b1);
    oc_cycle(1'b0);
    repeat (2) oc_cycle(1'b1);
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(rd[8:7]), 32'h2);
    oc_cycle(1'b1);
    wait_state(3'h5);
    chk({28'h0, rd[5:3], faultOe}, 32'h3);
    chk({31'h0, pwmOe}, 32'h0);
    chk(32'(midLen), 32'h3);
    expFlags |= 1;
    repeat (16) @(posedge clk_sys);
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(rd[2:0]), 32'h5);
    wait_state(3'h2);
    sense.fbOver <= 1'b1;
    sense.fbAboveGood <= 1'b1;
    wait_state(3'h7);
    chk({30'h0, hsOn, lsOn}, 32'h1);
    expFlags |= 8;
    sense.fbOver <= 1'b0;
    sense.fbAboveGood <= 1'b0;
    wait_state(3'h2);
    sense.fbUnder <= 1'b1;
    wait_state(3'h5);
    chk({28'h0, rd[5:3], faultOe}, 32'h7);
    expFlags |= 4;
    sense.fbUnder <= 1'b0;
    wait_state(3'h2);
    extPull <= 1'b1;
    wait_state(3'h4);
    chk({30'h0, faultOe, pwmOe}, 32'h0);
    expFlags |= 64;
    repeat (20) @(posedge clk_sys);
    wait_state(3'h4);
    extPull <= 1'b0;
    wait_state(3'h2);
    sense.junctHot <= 1'b1;
    sense.junctCool <= 1'b0;
    wait_state(3'h5);
    chk({28'h0, rd[5:3], pwmOe}, 32'hC);
    expFlags |= 32;
    sense.junctHot <= 1'b0;
    sense.junctCool <= 1'b1;
    wait_state(3'h2);
    sense.extOtHot <= 1'b1;
    sense.extOtCool <= 1'b0;
    wait_state(3'h5);
    chk({28'h0, rd[5:3], faultOe}, 32'hB);
    expFlags |= 16;
    sense.extOtHot <= 1'b0;
    sense.extOtCool <= 1'b1;
    wait_state(3'h2);
    sense.vinAboveOn <= 1'b0;
    sense.vinBelowOff <= 1'b1;
    wait_state(3'h5);
    chk({28'h0, rd[5:3], faultOe}, 32'h5);
    expFlags |= 2;
    sense.vinBelowOff <= 1'b0;
    sense.vinAboveOn <= 1'b1;
    wait_state(3'h2);
    apb(1'b1, 8'h00, 32'h0B);
    sense.leaderRetry <= 1'b0;
    sense.fbUnder <= 1'b1;
    repeat (10) @(posedge clk_sys);
    wait_state(3'h2);
    sense.fbUnder <= 1'b0;
    repeat (3) oc_cycle(1'b1);
    wait_state(3'h5);
    repeat (40) @(posedge clk_sys);
    wait_state(3'h5);
    sense.controlPin <= 1'b1;
    repeat (6) @(posedge clk_sys);
    sense.controlPin <= 1'b0;
    wait_state(3'h2);
    apb(1'b1, 8'h00, 32'h13);
    apb(1'b1, 8'h00, 32'h12);
    wait_state(3'h6);
    // this turn-on inside the turn-off delay breaks the host rule on purpose
    apb(1'b1, 8'h00, 32'h13);
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(rd[2:0]), 32'h6);
    wait_state(3'h2);
    apb(1'b0, 8'h14, 32'h0);
    chk(32'(rd[6:0]), 32'(expFlags));
    apb(1'b1, 8'h14, 32'h7F);
    apb(1'b0, 8'h14, 32'h0);
    chk(32'(rd[6:0]), 32'h0);
    chk({30'h0, goodOut, faultOut}, 32'h0);
    end_sim();
  end

  // watchdog: the sequence needs well under a tenth of this span
  initial begin
    #400000;
    n_fail++;
    end_sim();
  end
endmodule : testbench
